// ==== rtl/fbx_pkg.sv ====
// Shared constants and types for the 4-bit transfer and branch executor
package fbx_pkg;

	// Datapath widths
	localparam int FBX_NIB_W = 4;
	localparam int FBX_PC_W = 6;
	localparam int FBX_BANK_W = 4;
	localparam int FBX_OP_W = 8;
	localparam int FBX_RAM_AW = 5;
	localparam int FBX_RAM_WORDS = 32;
	localparam int FBX_STACK_DEPTH = 3;

	// Reset values
	localparam logic [3:0] FBX_NIB_RST = 4'h0;
	localparam logic [5:0] FBX_PC_RST = 6'h00;
	localparam logic [3:0] FBX_BANK_RST = 4'h0;
	localparam logic FBX_FLAG_RST = 1'b1;

	// Whole opcodes
	localparam logic [7:0] FBX_OPC_YREG_FROM_ACC = 8'h24;
	localparam logic [7:0] FBX_OPC_ACC_FROM_YREG = 8'h23;
	localparam logic [7:0] FBX_OPC_ZERO_ACC = 8'h2f;
	localparam logic [7:0] FBX_OPC_STORE_ACC = 8'h03;
	localparam logic [7:0] FBX_OPC_STORE_ACC_INC_Y = 8'h20;
	localparam logic [7:0] FBX_OPC_YREG_FROM_MEM = 8'h22;
	localparam logic [7:0] FBX_OPC_ACC_FROM_MEM = 8'h21;
	localparam logic [7:0] FBX_OPC_SWAP_ACC_MEM = 8'h2e;
	localparam logic [7:0] FBX_OPC_SUBROUTINE_RETURN = 8'h0f;

	// Upper nibbles of opcodes with a 4-bit immediate
	localparam logic [3:0] FBX_HI_YREG_IMMEDIATE = 4'h4;
	localparam logic [3:0] FBX_HI_STORE_IMM_INC_Y = 4'h6;
	localparam logic [3:0] FBX_HI_BANK_BUFFER_LOAD = 4'h1;

	// Upper six bits of opcodes with a bit or page operand
	localparam logic [5:0] FBX_HI_BIT_FORCE_ONE = 6'h0c;
	localparam logic [5:0] FBX_HI_BIT_CLEAR = 6'h0d;
	localparam logic [5:0] FBX_HI_BIT_TEST = 6'h0e;
	localparam logic [5:0] FBX_HI_XREG_IMMEDIATE = 6'h0f;

	// Top two bits of the long-address formats
	localparam logic [1:0] FBX_HI_JUMP_IF_FLAG = 2'b10;
	localparam logic [1:0] FBX_HI_CALL_IF_FLAG = 2'b11;

	// Decoded operations handled by this block
	typedef enum logic [4:0] {
		FBX_YREG_FROM_ACC,
		FBX_ACC_FROM_YREG,
		FBX_ZERO_ACC,
		FBX_STORE_ACC,
		FBX_STORE_ACC_INC_Y,
		FBX_YREG_FROM_MEM,
		FBX_ACC_FROM_MEM,
		FBX_SWAP_ACC_MEM,
		FBX_YREG_IMMEDIATE,
		FBX_STORE_IMM_INC_Y,
		FBX_XREG_IMMEDIATE,
		FBX_BIT_FORCE_ONE,
		FBX_BIT_CLEAR,
		FBX_BIT_TEST,
		FBX_JUMP_IF_FLAG,
		FBX_CALL_IF_FLAG,
		FBX_SUBROUTINE_RETURN,
		FBX_BANK_BUFFER_LOAD,
		FBX_FOREIGN
	} fbx_op_t;

endpackage

// ==== rtl/fbx_ram_if.sv ====
// Port bundle between the executor and its 32x4 data RAM
`timescale 1ns/10ps

interface fbx_ram_if;
	import fbx_pkg::*;

	logic [FBX_RAM_AW-1:0] addr;
	logic [FBX_NIB_W-1:0] wdata;
	logic we;
	logic [FBX_NIB_W-1:0] rdata;

	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ==== rtl/fbx_ram.sv ====
// 32x4 flip-flop data RAM with combinational read and clocked write
`timescale 1ns/10ps

module fbx_ram
	import fbx_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	fbx_ram_if.mem ram
);

	typedef struct packed {
		logic [FBX_RAM_WORDS-1:0][FBX_NIB_W-1:0] word;
	} fbx_ram_state_t;

	fbx_ram_state_t st;
	fbx_ram_state_t next_st;

	// Read is combinational so a read-modify-write fits one cycle
	assign ram.rdata = st.word[ram.addr];

	// Write port
	always_comb
	begin
		next_st = st;
		if (ram.we)
			next_st.word[ram.addr] = ram.wdata;
	end

	// Cleared on reset so simulation never reads unknowns
	always_ff @(posedge mclk)
	begin
		if (srst)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

endmodule

// ==== rtl/fbx_exec.sv ====
// Instruction executor: transfers, RAM bit ops, branch, call and return
//
// How it works
// - Y gets accumulator, accumulator kept, flag set
// - Accumulator gets all four Y bits, Y kept, flag set
// - Accumulator forced to zero, flag set
// - Accumulator written to RAM at X,Y, accumulator kept, flag set
// - Accumulator written to RAM at X,Y, then Y increments
// - Y loaded from RAM at X,Y, RAM untouched, flag set
// - Accumulator loaded from RAM at X,Y, RAM untouched, flag set
// - Accumulator and RAM word at X,Y swap in one instruction, flag set
// - Y loaded from the 4-bit immediate, flag set
// - Immediate written to RAM at X,Y, Y increments, flag set
// - X loaded from the 1-bit operand to pick the RAM page, flag set
// - Chosen RAM bit forced to one, others kept, flag set
// - Chosen RAM bit forced to zero, others kept, flag set
// - Flag takes the value of the chosen RAM bit
// - Flag one: branch loads PC from field and bank from buffer
// - Flag zero: branch falls through, then flag returns to one
// - PC steps through a fixed pseudo-random sequence, not binary
// - Flag one: call pushes next PC and bank, jumps, bank from buffer
// - Flag zero: call skips push, buffer restored from bank, flag set
// - Return pops top entry to PC and banks, deepest kept, flag set
// - Buffer load copies the 4-bit immediate into the bank buffer
`timescale 1ns/10ps

module fbx_exec
	import fbx_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	output logic [FBX_BANK_W+FBX_PC_W-1:0] rom_addr,
	input wire logic [FBX_OP_W-1:0] rom_data,
	output logic [FBX_NIB_W-1:0] acc,
	output logic [FBX_NIB_W-1:0] yreg,
	output logic xreg,
	output logic cond_flag,
	output logic [FBX_BANK_W-1:0] active_rom_bank,
	output logic [FBX_BANK_W-1:0] next_rom_bank_buffer,
	output logic foreign_op
);

	////////////////////////////////////////////////////////////////////////
	// Types and state

	typedef struct packed {
		logic [FBX_PC_W-1:0] pc;
		logic [FBX_BANK_W-1:0] bank;
	} fbx_frame_t;

	typedef struct packed {
		logic [FBX_NIB_W-1:0] acc;
		logic [FBX_NIB_W-1:0] yreg;
		logic xreg;
		logic flag;
		logic [FBX_PC_W-1:0] pc;
		logic [FBX_BANK_W-1:0] bank;
		logic [FBX_BANK_W-1:0] bank_buf;
		logic [FBX_STACK_DEPTH-1:0][$bits(fbx_frame_t)-1:0] stack;
		logic foreign;
	} fbx_state_t;

	fbx_state_t st;
	fbx_state_t next_st;
	fbx_op_t op;
	fbx_ram_if ram_bus ();

	logic [FBX_NIB_W-1:0] imm;
	logic [1:0] bit_sel;
	logic [FBX_PC_W-1:0] pc_seq;
	logic [FBX_NIB_W-1:0] mem_word;
	fbx_frame_t top_frame;
	fbx_frame_t push_frame;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Opcode classifier; anything not recognised belongs to other units
	function automatic fbx_op_t decode_op(input logic [FBX_OP_W-1:0] o);
		fbx_op_t r;
		r = FBX_FOREIGN;
		if (o[7:6] == FBX_HI_JUMP_IF_FLAG)
			r = FBX_JUMP_IF_FLAG;
		else if (o[7:6] == FBX_HI_CALL_IF_FLAG)
			r = FBX_CALL_IF_FLAG;
		else if (o[7:4] == FBX_HI_YREG_IMMEDIATE)
			r = FBX_YREG_IMMEDIATE;
		else if (o[7:4] == FBX_HI_STORE_IMM_INC_Y)
			r = FBX_STORE_IMM_INC_Y;
		else if (o[7:4] == FBX_HI_BANK_BUFFER_LOAD)
			r = FBX_BANK_BUFFER_LOAD;
		else if (o[7:2] == FBX_HI_BIT_FORCE_ONE)
			r = FBX_BIT_FORCE_ONE;
		else if (o[7:2] == FBX_HI_BIT_CLEAR)
			r = FBX_BIT_CLEAR;
		else if (o[7:2] == FBX_HI_BIT_TEST)
			r = FBX_BIT_TEST;
		else if (o[7:2] == FBX_HI_XREG_IMMEDIATE)
			r = FBX_XREG_IMMEDIATE;
		else if (o == FBX_OPC_YREG_FROM_ACC)
			r = FBX_YREG_FROM_ACC;
		else if (o == FBX_OPC_ACC_FROM_YREG)
			r = FBX_ACC_FROM_YREG;
		else if (o == FBX_OPC_ZERO_ACC)
			r = FBX_ZERO_ACC;
		else if (o == FBX_OPC_STORE_ACC)
			r = FBX_STORE_ACC;
		else if (o == FBX_OPC_STORE_ACC_INC_Y)
			r = FBX_STORE_ACC_INC_Y;
		else if (o == FBX_OPC_YREG_FROM_MEM)
			r = FBX_YREG_FROM_MEM;
		else if (o == FBX_OPC_ACC_FROM_MEM)
			r = FBX_ACC_FROM_MEM;
		else if (o == FBX_OPC_SWAP_ACC_MEM)
			r = FBX_SWAP_ACC_MEM;
		else if (o == FBX_OPC_SUBROUTINE_RETURN)
			r = FBX_SUBROUTINE_RETURN;
		return r;
	endfunction

	// Next program address: 6-bit XNOR feedback shift, taps 6 and 5.
	// Walks 63 states; all-ones is the lock-up code and is never reached
	// from reset or from a sane jump target.
	function automatic logic [FBX_PC_W-1:0] pc_step(
		input logic [FBX_PC_W-1:0] p);
		return {p[FBX_PC_W-2:0], ~(p[5] ^ p[4])};
	endfunction

	// Single increment for Y; wraps 15 to 0 through the 4-bit width
	function automatic logic [FBX_NIB_W-1:0] nib_inc(
		input logic [FBX_NIB_W-1:0] v);
		return FBX_NIB_W'(v + 1'b1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Field extraction and RAM hookup

	// The bit operand is stored least significant first in the opcode
	assign imm = rom_data[3:0];
	assign bit_sel = {rom_data[0], rom_data[1]};
	assign op = decode_op(rom_data);
	assign pc_seq = pc_step(st.pc);
	assign mem_word = ram_bus.rdata;
	assign top_frame = fbx_frame_t'(st.stack[0]);
	assign push_frame = '{pc: pc_seq, bank: st.bank};

	// RAM sits at X,Y; the address is stable for the whole cycle
	assign ram_bus.addr = {st.xreg, st.yreg};

	fbx_ram u_ram (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.ram(ram_bus.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// RAM write data: everything lands at the clock edge that ends the
	// instruction, so read-modify-write never spans two cycles

	always_comb
	begin
		ram_bus.wdata = mem_word;
		ram_bus.we = 1'b0;
		unique case (op)
			FBX_STORE_ACC, FBX_STORE_ACC_INC_Y, FBX_SWAP_ACC_MEM:
			begin
				ram_bus.wdata = st.acc;
				ram_bus.we = 1'b1;
			end
			FBX_STORE_IMM_INC_Y:
			begin
				ram_bus.wdata = imm;
				ram_bus.we = 1'b1;
			end
			FBX_BIT_FORCE_ONE:
			begin
				ram_bus.wdata[bit_sel] = 1'b1;
				ram_bus.we = 1'b1;
			end
			FBX_BIT_CLEAR:
			begin
				ram_bus.wdata[bit_sel] = 1'b0;
				ram_bus.we = 1'b1;
			end
			default:
			begin
				ram_bus.we = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register next state. The flag ends at one for every instruction
	// here except the bit test; foreign opcodes only advance the PC and raise foreign_op.

	always_comb
	begin
		next_st = st;
		next_st.pc = pc_seq;
		next_st.foreign = 1'b0;
		unique case (op)
			FBX_YREG_FROM_ACC:
			begin
				next_st.yreg = st.acc;
				next_st.flag = 1'b1;
			end
			FBX_ACC_FROM_YREG:
			begin
				next_st.acc = st.yreg;
				next_st.flag = 1'b1;
			end
			FBX_ZERO_ACC:
			begin
				next_st.acc = FBX_NIB_RST;
				next_st.flag = 1'b1;
			end
			FBX_STORE_ACC:
			begin
				next_st.flag = 1'b1;
			end
			FBX_STORE_ACC_INC_Y, FBX_STORE_IMM_INC_Y:
			begin
				// Y moves after the store, which used the old Y
				next_st.yreg = nib_inc(st.yreg);
				next_st.flag = 1'b1;
			end
			FBX_YREG_FROM_MEM:
			begin
				next_st.yreg = mem_word;
				next_st.flag = 1'b1;
			end
			FBX_ACC_FROM_MEM:
			begin
				next_st.acc = mem_word;
				next_st.flag = 1'b1;
			end
			FBX_SWAP_ACC_MEM:
			begin
				next_st.acc = mem_word;
				next_st.flag = 1'b1;
			end
			FBX_YREG_IMMEDIATE:
			begin
				next_st.yreg = imm;
				next_st.flag = 1'b1;
			end
			FBX_XREG_IMMEDIATE:
			begin
				next_st.xreg = rom_data[0];
				next_st.flag = 1'b1;
			end
			FBX_BIT_FORCE_ONE, FBX_BIT_CLEAR:
			begin
				next_st.flag = 1'b1;
			end
			FBX_BIT_TEST:
			begin
				next_st.flag = mem_word[bit_sel];
			end
			FBX_JUMP_IF_FLAG:
			begin
				if (st.flag)
				begin
					// Same bank in the buffer gives a short jump
					next_st.pc = rom_data[FBX_PC_W-1:0];
					next_st.bank = st.bank_buf;
				end
				next_st.flag = 1'b1;
			end
			FBX_CALL_IF_FLAG:
			begin
				if (st.flag)
				begin
					// Push shifts the deepest frame out: four nested
					// calls lose the oldest return silently
					next_st.stack[0] = push_frame;
					next_st.stack[1] = st.stack[0];
					next_st.stack[2] = st.stack[1];
					next_st.pc = rom_data[FBX_PC_W-1:0];
					next_st.bank = st.bank_buf;
				end
				else
				begin
					next_st.bank_buf = st.bank;
				end
				next_st.flag = 1'b1;
			end
			FBX_SUBROUTINE_RETURN:
			begin
				// Deepest frame is duplicated, not cleared, on a pop
				next_st.pc = top_frame.pc;
				next_st.bank = top_frame.bank;
				next_st.bank_buf = top_frame.bank;
				next_st.stack[0] = st.stack[1];
				next_st.stack[1] = st.stack[2];
				next_st.flag = 1'b1;
			end
			FBX_BANK_BUFFER_LOAD:
			begin
				next_st.bank_buf = imm;
				next_st.flag = 1'b1;
			end
			FBX_FOREIGN:
			begin
				next_st.foreign = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register: one instruction retires per enabled edge

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			st <= '0;
			st.flag <= FBX_FLAG_RST;
			st.pc <= FBX_PC_RST;
			st.bank <= FBX_BANK_RST;
			st.bank_buf <= FBX_BANK_RST;
		end
		else if (ce)
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign rom_addr = {st.bank, st.pc};
	assign acc = st.acc;
	assign yreg = st.yreg;
	assign xreg = st.xreg;
	assign cond_flag = st.flag;
	assign active_rom_bank = st.bank;
	assign next_rom_bank_buffer = st.bank_buf;
	assign foreign_op = st.foreign;

endmodule

// ==== bench/fbx_rom_model.sv ====
// Program ROM model feeding opcodes to the executor
`timescale 1ns/10ps
module fbx_rom_model
	import fbx_pkg::*;
(
	input logic [FBX_BANK_W+FBX_PC_W-1:0] rom_addr,
	output logic [FBX_OP_W-1:0] rom_data
);
	logic [FBX_OP_W-1:0] mem [0:1023];

	// Blank words hold an opcode this block does not execute
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem[i] = 8'h00;
	end

	// Read is combinational: the executor takes it on the same edge
	assign rom_data = mem[rom_addr];
endmodule

// ==== bench/fbx_exec_monitor.sv ====
// Port assertions for the executor, bound to its top module
`timescale 1ns/10ps
module fbx_exec_monitor
	import fbx_pkg::*;
(
	input logic mclk,
	input logic srst,
	input logic ce,
	input logic [FBX_BANK_W+FBX_PC_W-1:0] rom_addr,
	input logic [FBX_OP_W-1:0] rom_data,
	input logic [FBX_NIB_W-1:0] acc,
	input logic [FBX_NIB_W-1:0] yreg,
	input logic xreg,
	input logic cond_flag,
	input logic [FBX_BANK_W-1:0] active_rom_bank,
	input logic [FBX_BANK_W-1:0] next_rom_bank_buffer
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////
	// Transfers and immediates
	property p_zero_acc;
		ce && rom_data == FBX_OPC_ZERO_ACC |=> acc == 4'h0 && cond_flag;
	endproperty
	a_zero_acc: assert property (p_zero_acc)
		else $error("acc not cleared");
	property p_yreg_imm;
		ce && rom_data[7:4] == FBX_HI_YREG_IMMEDIATE
			|=> yreg == $past(rom_data[3:0]) && cond_flag;
	endproperty
	a_yreg_imm: assert property (p_yreg_imm)
		else $error("yreg immediate wrong");
	property p_imm_inc;
		ce && rom_data[7:4] == FBX_HI_STORE_IMM_INC_Y
			|=> yreg == $past(yreg) + 4'h1 && cond_flag;
	endproperty
	a_imm_inc: assert property (p_imm_inc)
		else $error("yreg step wrong");
	property p_xreg_imm;
		ce && rom_data[7:1] == {FBX_HI_XREG_IMMEDIATE, 1'b0}
			|=> xreg == $past(rom_data[0]) && cond_flag;
	endproperty
	a_xreg_imm: assert property (p_xreg_imm)
		else $error("xreg immediate wrong");

	////////////////////////////////////////
	// Flow control, built from fetch sequences
	sequence s_jump;
		ce && rom_data[7:6] == FBX_HI_JUMP_IF_FLAG;
	endsequence
	sequence s_call;
		ce && rom_data[7:6] == FBX_HI_CALL_IF_FLAG;
	endsequence
	sequence s_ret;
		ce && rom_data == FBX_OPC_SUBROUTINE_RETURN;
	endsequence
	property p_jump_taken;
		s_jump ##0 cond_flag |=> rom_addr ==
			{$past(next_rom_bank_buffer), $past(rom_data[5:0])};
	endproperty
	a_jump_taken: assert property (p_jump_taken)
		else $error("branch target wrong");
	property p_jump_fall;
		s_jump ##0 !cond_flag |=> cond_flag && rom_addr ==
			{$past(rom_addr[9:6]), $past(rom_addr[4:0]),
			~($past(rom_addr[5]) ^ $past(rom_addr[4]))};
	endproperty
	a_jump_fall: assert property (p_jump_fall)
		else $error("fall through wrong");
	property p_call_taken;
		s_call ##0 cond_flag |=> rom_addr ==
			{$past(next_rom_bank_buffer), $past(rom_data[5:0])};
	endproperty
	a_call_taken: assert property (p_call_taken)
		else $error("call target wrong");
	property p_call_skip;
		s_call ##0 !cond_flag |=> cond_flag &&
			next_rom_bank_buffer == $past(active_rom_bank);
	endproperty
	a_call_skip: assert property (p_call_skip)
		else $error("skipped call wrong");
	// The return lands after the call with the bank it had then
	property p_call_return;
		s_call ##0 cond_flag ##1 s_ret |=> rom_addr ==
			{$past(active_rom_bank, 2), $past(rom_addr[4:0], 2),
			~($past(rom_addr[5], 2) ^ $past(rom_addr[4], 2))};
	endproperty
	a_call_return: assert property (p_call_return)
		else $error("return address wrong");
endmodule

bind fbx_exec fbx_exec_monitor u_monitor (
	.mclk(mclk), .srst(srst), .ce(ce), .rom_addr(rom_addr),
	.rom_data(rom_data), .acc(acc), .yreg(yreg), .xreg(xreg),
	.cond_flag(cond_flag), .active_rom_bank(active_rom_bank),
	.next_rom_bank_buffer(next_rom_bank_buffer)
);

// ==== bench/fbx_exec_tb_top.sv ====
// Self-checking bench for the transfer and branch executor
`timescale 1ns/10ps
module fbx_exec_tb_top import fbx_pkg::*;;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b0;
	logic [9:0] rom_addr, a;
	logic [7:0] rom_data;
	logic [3:0] acc, yreg, bank, rom_buf;
	logic xreg, flag, foreign_op;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;

	// 100 MHz core clock
	always #5 mclk = ~mclk;

	fbx_rom_model i_rom (.rom_addr(rom_addr), .rom_data(rom_data));
	fbx_exec i_dut (.mclk(mclk), .srst(srst), .ce(ce),
		.rom_addr(rom_addr), .rom_data(rom_data), .acc(acc),
		.yreg(yreg), .xreg(xreg), .cond_flag(flag),
		.active_rom_bank(bank), .next_rom_bank_buffer(rom_buf),
		.foreign_op(foreign_op));

	////////////////////////////////////////
	// Fetch protocol: opcode placed at the fetch address off the edge
	task put(input logic [7:0] x);
		@(negedge mclk);
		i_rom.mem[rom_addr] = x;
		ce = 1'b1;
	endtask
	// Single step; ce drops so results hold while they are checked
	task op(input logic [7:0] x);
		put(x);
		@(negedge mclk);
		ce = 1'b0;
	endtask
	task chk(input string n, input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	function automatic logic [5:0] nx(input logic [5:0] p);
		return {p[4:0], ~(p[5] ^ p[4])};
	endfunction
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard, far above the hundred or so cycles the run needs
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			tally_and_finish;
		end
	end

	////////////////////////////////////////
	initial
	begin
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		chk("flag", 1'b1, flag);
		op(8'h4f);
		chk("yreg", 4'hf, yreg);
		op(FBX_OPC_ZERO_ACC);
		chk("acc", 4'h0, acc);
		op(FBX_OPC_ACC_FROM_YREG);
		chk("acc", 4'hf, acc);
		op(8'h42);
		op(FBX_OPC_YREG_FROM_ACC);
		chk("yreg", 4'hf, yreg);
		op(8'h3d);
		chk("xreg", 1'b1, xreg);
		op(8'h65);
		chk("yreg", 4'h0, yreg);
		op(8'h4f);
		op(FBX_OPC_SWAP_ACC_MEM);
		chk("acc", 4'h5, acc);
		// Swapping back proves the word took the old accumulator
		op(FBX_OPC_SWAP_ACC_MEM);
		chk("acc", 4'hf, acc);
		op(FBX_OPC_STORE_ACC);
		op(FBX_OPC_ZERO_ACC);
		op(FBX_OPC_ACC_FROM_MEM);
		chk("acc", 4'hf, acc);
		op(8'h49);
		op(FBX_OPC_ACC_FROM_YREG);
		op(8'h4f);
		op(FBX_OPC_STORE_ACC_INC_Y);
		chk("yreg", 4'h0, yreg);
		op(8'h4f);
		op(FBX_OPC_ZERO_ACC);
		op(FBX_OPC_ACC_FROM_MEM);
		chk("acc", 4'h9, acc);
		// Word at X=1, Y=15 still holds 9 from the incrementing store
		op(8'h4f);
		op(FBX_OPC_YREG_FROM_MEM);
		chk("yreg", 4'h9, yreg);
		op(8'h00);
		chk("foreign_op", 1'b1, foreign_op);
		$display("test transfers done");
		// Each bit of an empty word set, tested, cleared, tested
		for (int b = 0; b < 4; b++)
		begin
			logic [1:0] bs;
			bs = {b[0], b[1]};
			op({FBX_HI_BIT_FORCE_ONE, bs});
			op(FBX_OPC_ACC_FROM_MEM);
			chk("acc", 4'h1 << b, acc);
			op({FBX_HI_BIT_TEST, bs});
			chk("flag", 1'b1, flag);
			op({FBX_HI_BIT_CLEAR, bs});
			op(FBX_OPC_ACC_FROM_MEM);
			chk("acc", 4'h0, acc);
			op({FBX_HI_BIT_TEST, bs});
			chk("flag", 1'b0, flag);
		end
		$display("test bits done");
		a = rom_addr;
		op(8'h8a);
		chk("rom_addr", {a[9:6], nx(a[5:0])}, rom_addr);
		chk("flag", 1'b1, flag);
		op(8'h13);
		chk("rom_buf", 4'h3, rom_buf);
		op(8'h85);
		chk("rom_addr", 10'h0c5, rom_addr);
		op(8'h12);
		a = rom_addr;
		put(8'hc7);
		op(FBX_OPC_SUBROUTINE_RETURN);
		chk("rom_addr", {4'h3, nx(a[5:0])}, rom_addr);
		chk("rom_buf", 4'h3, rom_buf);
		chk("bank", 4'h3, bank);
		op(8'h12);
		op({FBX_HI_BIT_TEST, 2'b00});
		op(8'hc7);
		chk("rom_buf", 4'h3, rom_buf);
		chk("flag", 1'b1, flag);
		$display("test flow done");
		tally_and_finish;
	end
endmodule
